// [dmr_regs.sv]
// dma channel request mask and enable registers behind an axi4-lite slave
// Notes on behaviour
// - the request-mask clear register sits at 0x40010024 and resets to zero.
// - a one written to a mask clear bit clears that channel's request mask.
// - a zero written to a mask clear bit leaves that mask bit as it is.
// - bits 31 to 16 of the mask clear and enable set registers are reserved.
// - bits 15 to 8 map to the second uart, first spi, filter, converters and dac.
// - bits 7 to 0 map to the i2c master and slave, the uart and the second spi.
// - bit 9 works only on the variant that holds the first converter.
// - the channel-enable set register sits at 0x40010028 and resets to zero.
// - a one written to an enable set bit enables that channel.
// - a zero written to an enable set bit leaves that channel's enable as it is.
// - reading the enable set register returns every channel's enable state.
// - a one written to the mask set register masks a channel; reads give the masks.
// - a channel's enable clears itself when its dma cycle completes.
`timescale 1ns/1ps
`default_nettype none
module dmr_regs
	import dmr_pkg::*;
#(
	parameter logic first_converter_present = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] peripheral_request,
	input wire logic [15:0] channel_cycle_done,
	output logic [15:0] channel_service,
	output logic [15:0] channel_enabled,
	output logic [15:0] channel_masked
);
	// write and read sides run as two independent two-state machines
	typedef enum logic [1:0] {
		dmr_wr_idle = 2'h1,
		dmr_wr_resp = 2'h2
	} dmr_wr_state_t;

	typedef enum logic [1:0] {
		dmr_rd_idle = 2'h1,
		dmr_rd_data = 2'h2
	} dmr_rd_state_t;

	// address decode shared by read and write paths
	// unmapped addresses fall through to none and answer with an error
	function automatic dmr_sel_t decode(input logic [31:0] addr);
		dmr_sel_t sel;
		sel = dmr_sel_none;
		if (addr == dmr_request_mask_set_addr) begin
			sel = dmr_sel_mask_set;
		end else if (addr == dmr_request_mask_clear_addr) begin
			sel = dmr_sel_mask_clear;
		end else if (addr == dmr_channel_enable_set_addr) begin
			sel = dmr_sel_enable_set;
		end else if (addr == dmr_channel_enable_clear_addr) begin
			sel = dmr_sel_enable_clear;
		end
		return sel;
	endfunction : decode

	// bit mask of channels that exist on this variant
	function automatic logic [15:0] implemented_mask(input logic converter_present);
		logic [15:0] m;
		m = 16'hFFFF;
		m[first_converter_channel] = converter_present;
		return m;
	endfunction : implemented_mask

	// write side state
	dmr_wr_state_t wr_state;
	dmr_wr_state_t next_wr_state;
	logic aw_held;
	logic next_aw_held;
	logic w_held;
	logic next_w_held;
	logic [31:0] aw_addr;
	logic [31:0] next_aw_addr;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	logic wr_fire;
	dmr_sel_t wr_sel;
	logic [15:0] wr_bits;

	// read side state
	dmr_rd_state_t rd_state;
	dmr_rd_state_t next_rd_state;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;
	dmr_sel_t rd_sel;

	// per-channel strobes and state
	logic [15:0] set_mask;
	logic [15:0] clear_mask;
	logic [15:0] set_enable;
	logic [15:0] clear_enable;
	logic [15:0] mask_state;
	logic [15:0] enable_state;

	// write channel: address and data taken in either order
	assign s_axi_awready = (wr_state == dmr_wr_idle) && !aw_held;
	assign s_axi_wready = (wr_state == dmr_wr_idle) && !w_held;
	assign s_axi_bvalid = (wr_state == dmr_wr_resp);
	assign s_axi_bresp = bresp;
	// a write acts only once both halves are held, never on a lone address
	assign wr_fire = (wr_state == dmr_wr_idle) && aw_held && w_held;
	assign wr_sel = decode(aw_addr);

	// only lanes 0 and 1 carry channel bits; upper lanes are reserved
	logic [15:0] lane_bits;
	for (genvar b = 0; b < 2; b++) begin : g_lane
		assign lane_bits[8 * b +: 8] = w_data[8 * b +: 8] & {8{w_strb[b]}};
	end

	// absent channel bits are dropped before any cell sees them
	always_comb begin
		wr_bits = lane_bits & implemented_mask(first_converter_present);
	end

	// write side next state
	always_comb begin
		next_wr_state = wr_state;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bresp = bresp;
		unique case (wr_state)
			dmr_wr_idle: begin
				if (s_axi_awvalid && s_axi_awready) begin
					next_aw_held = 1'b1;
					next_aw_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					next_w_held = 1'b1;
					next_w_data = s_axi_wdata;
					next_w_strb = s_axi_wstrb;
				end
				if (wr_fire) begin
					next_aw_held = 1'b0;
					next_w_held = 1'b0;
					// response is fixed when the write acts, so it stays put while bvalid waits
					next_bresp = (wr_sel == dmr_sel_none) ? dmr_resp_slverr : dmr_resp_okay;
					next_wr_state = dmr_wr_resp;
				end
			end
			dmr_wr_resp: begin
				if (s_axi_bready) begin
					next_wr_state = dmr_wr_idle;
				end
			end
		endcase
	end

	// write side registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= dmr_wr_idle;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bresp <= dmr_resp_okay;
		end else begin
			wr_state <= next_wr_state;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bresp <= next_bresp;
		end
	end

	// register write effects: ones act, zeros leave bits untouched
	always_comb begin
		set_mask = 16'h0000;
		clear_mask = 16'h0000;
		set_enable = 16'h0000;
		clear_enable = 16'h0000;
		if (wr_fire) begin
			unique case (wr_sel)
				dmr_sel_mask_set: set_mask = wr_bits;
				dmr_sel_mask_clear: clear_mask = wr_bits;
				dmr_sel_enable_set: set_enable = wr_bits;
				dmr_sel_enable_clear: clear_enable = wr_bits;
				dmr_sel_none: set_mask = 16'h0000;
			endcase
		end
	end

	// one cell per channel, bit index equals channel number
	// a set beats a completion in the same cycle, so a fresh enable is never lost
	for (genvar i = 0; i < dmr_num_channels; i++) begin : g_chan
		dmr_chan_cell #(
			.implemented((i != first_converter_channel) || first_converter_present)
		) u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.set_mask(set_mask[i]),
			.clear_mask(clear_mask[i]),
			.set_enable(set_enable[i]),
			.clear_enable(clear_enable[i]),
			.cycle_done(channel_cycle_done[i]),
			.request(peripheral_request[i]),
			.mask(mask_state[i]),
			.enable(enable_state[i]),
			.service(channel_service[i])
		);
	end

	// status views for the rest of the controller
	assign channel_enabled = enable_state;
	assign channel_masked = mask_state;

	// read channel
	// arready stays low while data waits, so a second read cannot overtake it
	logic [31:0] mask_word;
	logic [31:0] enable_word;
	assign mask_word = {dmr_reserved_read, mask_state};
	assign enable_word = {dmr_reserved_read, enable_state};

	assign s_axi_arready = (rd_state == dmr_rd_idle);
	assign s_axi_rvalid = (rd_state == dmr_rd_data);
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign rd_sel = decode(s_axi_araddr);

	// read data is captured when the address is taken, then held until rready
	always_comb begin
		next_rd_state = rd_state;
		next_rdata = rdata;
		next_rresp = rresp;
		unique case (rd_state)
			dmr_rd_idle: begin
				if (s_axi_arvalid) begin
					next_rresp = dmr_resp_okay;
					unique case (rd_sel)
						dmr_sel_mask_set,
						dmr_sel_mask_clear: begin
							next_rdata = mask_word;
						end
						dmr_sel_enable_set,
						dmr_sel_enable_clear: begin
							next_rdata = enable_word;
						end
						dmr_sel_none: begin
							next_rdata = 32'h0000_0000;
							next_rresp = dmr_resp_slverr;
						end
					endcase
					next_rd_state = dmr_rd_data;
				end
			end
			dmr_rd_data: begin
				if (s_axi_rready) begin
					next_rd_state = dmr_rd_idle;
				end
			end
		endcase
	end

	// read side registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= dmr_rd_idle;
			rdata <= 32'h0000_0000;
			rresp <= dmr_resp_okay;
		end else begin
			rd_state <= next_rd_state;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule : dmr_regs
`default_nettype wire

// [dmr_pkg.sv]
// constants for the dma channel mask and enable register block
package dmr_pkg;
	localparam int dmr_num_channels = 16;
	localparam int dmr_addr_width = 32;
	localparam int dmr_data_width = 32;

	// register byte addresses
	localparam logic [31:0] dmr_request_mask_set_addr = 32'h4001_0020;
	localparam logic [31:0] dmr_request_mask_clear_addr = 32'h4001_0024;
	localparam logic [31:0] dmr_channel_enable_set_addr = 32'h4001_0028;
	localparam logic [31:0] dmr_channel_enable_clear_addr = 32'h4001_002C;

	// reset values
	localparam logic [31:0] dmr_request_mask_clear_reset = 32'h0000_0000;
	localparam logic [31:0] dmr_channel_enable_set_reset = 32'h0000_0000;
	localparam logic [15:0] dmr_mask_reset = 16'h0000;
	localparam logic [15:0] dmr_enable_reset = 16'h0000;

	// channel field positions
	localparam int second_uart_receive_channel = 15;
	localparam int second_uart_transmit_channel = 14;
	localparam int first_spi_receive_channel = 13;
	localparam int first_spi_transmit_channel = 12;
	localparam int filter_result_channel = 11;
	localparam int second_converter_channel = 10;
	localparam int first_converter_channel = 9;
	localparam int dac_channel = 8;
	localparam int i2c_master_receive_channel = 7;
	localparam int i2c_master_transmit_channel = 6;
	localparam int i2c_slave_receive_channel = 5;
	localparam int i2c_slave_transmit_channel = 4;
	localparam int uart_receive_channel = 3;
	localparam int uart_transmit_channel = 2;
	localparam int second_spi_receive_channel = 1;
	localparam int second_spi_transmit_channel = 0;

	// reserved field
	localparam int dmr_reserved_lsb = 16;
	localparam int dmr_reserved_msb = 31;
	localparam logic [15:0] dmr_reserved_read = 16'h0000;

	// bus responses
	localparam logic [1:0] dmr_resp_okay = 2'h0;
	localparam logic [1:0] dmr_resp_slverr = 2'h2;

	typedef enum logic [4:0] {
		dmr_sel_none = 5'h01,
		dmr_sel_mask_set = 5'h02,
		dmr_sel_mask_clear = 5'h04,
		dmr_sel_enable_set = 5'h08,
		dmr_sel_enable_clear = 5'h10
	} dmr_sel_t;
endpackage : dmr_pkg

// [dmr_chan_cell.sv]
// state of one dma channel: request mask, enable and gated request
`timescale 1ns/1ps
`default_nettype none
module dmr_chan_cell
	import dmr_pkg::*;
#(
	parameter logic implemented = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set_mask,
	input wire logic clear_mask,
	input wire logic set_enable,
	input wire logic clear_enable,
	input wire logic cycle_done,
	input wire logic request,
	output logic mask,
	output logic enable,
	output logic service
);
	logic next_mask;
	logic next_enable;
	logic next_service;

	always_comb begin
		next_mask = mask;
		next_enable = enable;
		if (set_mask) begin
			next_mask = 1'b1;
		end else if (clear_mask) begin
			next_mask = 1'b0;
		end
		if (set_enable) begin
			next_enable = 1'b1;
		end else if (clear_enable || cycle_done) begin
			next_enable = 1'b0;
		end
		if (!implemented) begin
			next_mask = 1'b0;
			next_enable = 1'b0;
		end
		next_service = implemented && request && next_enable && !next_mask;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask <= 1'b0;
			enable <= 1'b0;
			service <= 1'b0;
		end else begin
			mask <= next_mask;
			enable <= next_enable;
			service <= next_service;
		end
	end
endmodule : dmr_chan_cell
`default_nettype wire

// [dmr_regs_properties.sv]
// assertions for the dma mask and enable register block
`timescale 1ns/1ps
`default_nettype none
module dmr_regs_properties #(
	parameter logic first_converter_present = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] peripheral_request,
	input wire logic [15:0] channel_cycle_done,
	input wire logic [15:0] channel_service,
	input wire logic [15:0] channel_enabled,
	input wire logic [15:0] channel_masked
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two edges after");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	reserved_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");
	mask_by_write_a: assert property ($changed(channel_masked) |-> $rose(s_axi_bvalid))
		else $error("mask changed without a write");
	enable_by_write_a: assert property (
		|(channel_enabled & ~$past(channel_enabled)) |-> $rose(s_axi_bvalid))
		else $error("enable rose without a write");
	done_clears_a: assert property (
		s_axi_awready && |channel_cycle_done |=> (channel_enabled & $past(channel_cycle_done)) == 16'h0000)
		else $error("enable kept after cycle done");
	service_gate_a: assert property (
		channel_service == ($past(peripheral_request) & channel_enabled & ~channel_masked))
		else $error("service not request and enabled and unmasked");
	reset_state_a: assert property (disable iff (1'b0)
		!aresetn |=> channel_enabled == 16'h0000 && channel_masked == 16'h0000 && !s_axi_bvalid)
		else $error("state not cleared by reset");
	variant_bit_a: assert property (!first_converter_present |-> !channel_enabled[9])
		else $error("absent converter channel enabled");
	cover property (|channel_service);
	cover property ($fell(channel_enabled[0]));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : dmr_regs_properties
bind dmr_regs dmr_regs_properties #(.first_converter_present(first_converter_present)) chk_u (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .peripheral_request, .channel_cycle_done, .channel_service, .channel_enabled,
	.channel_masked);
`default_nettype wire

// [dmr_periph_model.sv]
// model of the requesting peripherals: drop request when serviced, then report cycle done
`timescale 1ns/1ps
`default_nettype none
module dmr_periph_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] want_req,
	input wire logic slow,
	input wire logic [15:0] channel_service,
	output logic [15:0] peripheral_request,
	output logic [15:0] channel_cycle_done
);
	logic [15:0] pend, next_pend, next_req, next_done;
	logic [1:0] cnt, next_cnt;
	always_comb begin
		next_pend = pend | channel_service;
		next_done = 16'h0000;
		next_cnt = (|pend) ? cnt + 2'd1 : 2'd0;
		if (|pend && (!slow || cnt == 2'd3)) begin
			next_done = pend;
			next_pend = 16'h0000;
			next_cnt = 2'd0;
		end
		next_req = want_req & ~next_pend;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend <= 16'h0000;
			cnt <= 2'd0;
			peripheral_request <= 16'h0000;
			channel_cycle_done <= 16'h0000;
		end else begin
			pend <= next_pend;
			cnt <= next_cnt;
			peripheral_request <= next_req;
			channel_cycle_done <= next_done;
		end
	end
endmodule : dmr_periph_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the dma mask and enable register block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dmr_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] want_req = 16'h0000, peripheral_request, channel_cycle_done;
	logic [15:0] channel_service, channel_enabled, channel_masked;
	logic [15:0] v_enabled, v_masked;
	int err_count = 0, cmp_count = 0;
	dmr_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .peripheral_request, .channel_cycle_done, .channel_service,
		.channel_enabled, .channel_masked);
	dmr_regs #(.first_converter_present(1'b0)) dut_v (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .peripheral_request, .channel_cycle_done,
		.channel_service(), .channel_enabled(v_enabled), .channel_masked(v_masked));
	dmr_periph_model periph_u (.aclk, .aresetn, .want_req, .slow, .channel_service,
		.peripheral_request, .channel_cycle_done);
	initial begin
		forever #20 aclk = ~aclk;
	end
	task automatic print_verdict();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
		if (n == 50) begin
			err_count++;
			print_verdict();
		end
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, exp);
		check({30'h0, s_axi_rresp}, {30'h0, er});
		if (n == 50) begin
			err_count++;
			print_verdict();
		end
	endtask : rd
	task automatic wait_en(input logic [15:0] exp);
		int n;
		for (n = 0; n < 40 && channel_enabled !== exp; n++) @(posedge aclk);
		check({16'h0, channel_enabled}, {16'h0, exp});
		if (n == 40) begin
			err_count++;
			print_verdict();
		end
	endtask : wait_en
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(dmr_request_mask_clear_addr, 32'h0000_0000, dmr_resp_okay);
		rd(dmr_channel_enable_set_addr, 32'h0000_0000, dmr_resp_okay);
		wr(dmr_request_mask_set_addr, 32'hFFFF_FFFF, dmr_resp_okay);
		rd(dmr_request_mask_set_addr, 32'h0000_FFFF, dmr_resp_okay);
		check({16'h0, v_masked}, 32'h0000_FDFF);
		wr(dmr_request_mask_clear_addr, 32'h0000_A5A5, dmr_resp_okay);
		wr(dmr_request_mask_clear_addr, 32'hFFFF_0000, dmr_resp_okay);
		rd(dmr_request_mask_set_addr, 32'h0000_5A5A, dmr_resp_okay);
		for (int i = 0; i < 16; i++) begin
			wr(dmr_channel_enable_set_addr, 32'hFFFF_0000 | (32'h1 << i), dmr_resp_okay);
			rd(dmr_channel_enable_set_addr, (32'h2 << i) - 32'h1, dmr_resp_okay);
		end
		check({16'h0, v_enabled}, 32'h0000_FDFF);
		wr(dmr_channel_enable_clear_addr, 32'hFFFF_FFFF, dmr_resp_okay);
		rd(dmr_channel_enable_set_addr, 32'h0000_0000, dmr_resp_okay);
		wr(32'h4001_0030, 32'h0000_FFFF, dmr_resp_slverr);
		rd(32'h4001_0030, 32'h0000_0000, dmr_resp_slverr);
		wr(dmr_channel_enable_set_addr, 32'h0000_000F, dmr_resp_okay);
		slow <= 1'b1;
		want_req <= 16'h000F;
		wait_en(16'h000A);
		rd(dmr_channel_enable_set_addr, 32'h0000_000A, dmr_resp_okay);
		slow <= 1'b0;
		wr(dmr_request_mask_clear_addr, 32'h0000_000A, dmr_resp_okay);
		wait_en(16'h0000);
		check({16'h0, channel_masked}, 32'h0000_5A50);
		wr(dmr_channel_enable_set_addr, 32'h0000_0100, dmr_resp_okay);
		wait_en(16'h0100);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(dmr_channel_enable_set_addr, 32'h0000_0000, dmr_resp_okay);
		rd(dmr_request_mask_clear_addr, 32'h0000_0000, dmr_resp_okay);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
